// *** ueb_register_bank.v ***
// Register bank of a host-controlled UART: map decode, status and interrupt sources.
`timescale 1ns/1ps
`include "ueb_defs.vh"
// How it works
// - Shaded enhanced bits need enhanced_feature_ctrl bit 4.
// - int_enable_reg bits gate each interrupt source except GPIO, which enhanced_feature_ctrl bit 4 gates.
// - Unmasked sources are reported in int_status_reg.
// - FIFO interrupt mode needs FIFO and receive enables.
// - Receive interrupt asserts at trigger level.
// - Receive interrupt withdraws below trigger level.
// - Status bits 2,3 follow the receive interrupt.
// - Data ready sets when character enters FIFO.
// - Data ready clears only when FIFO empty.
// - Receive holding is read only.
// - Transmit holding is write only.
// - int_enable_reg reads back last written value, except bits 7:4 written without enhanced_feature_ctrl bit 4.
// - Time-out after four characters plus twelve bits.
// - Status bit 0 high when nothing pending.
module ueb_register_bank (
    input wire mclk,
    input wire nrst,
    input wire [3:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdData,
    output reg regRdValid,
    input wire [6:0] rxFifoCount,
    input wire [7:0] rxFifoHead,
    input wire rxPush,
    input wire bitTick,
    input wire txEmpty,
    input wire [7:1] lineStatusIn,
    input wire modemInt,
    input wire [7:0] gpioIn,
    output reg rxPop,
    output reg txPush,
    output reg [7:0] txData,
    output reg rxFifoClear,
    output reg txFifoClear,
    output reg irq,
    output reg [7:0] divisorLow,
    output reg [7:0] divisorHigh,
    output reg [7:0] divisorFraction,
    output reg [7:0] lineCtrl,
    output reg [7:0] enhancedCtrl,
    output reg [7:0] extraCtrl,
    output reg [7:0] gpioOut,
    output reg [7:0] ioPinCtrl
);
    // Trigger level selected by the two fifo_ctrl trigger bits.
    function [6:0] trigLevel;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: trigLevel = `UEB_TRIG0;
                2'h1: trigLevel = `UEB_TRIG1;
                2'h2: trigLevel = `UEB_TRIG2;
                default: trigLevel = `UEB_TRIG3;
            endcase
        end
    endfunction

    // Time-out in bit times: data, parity and stop bits follow line_ctrl.
    function [6:0] timeoutBits;
        input [7:0] line_ctrl;
        reg [6:0] perChar;
        begin
            perChar = `UEB_FRAME_BASE + {5'h00, line_ctrl[1:0]} + {6'h00, line_ctrl[2]} + {6'h00, line_ctrl[3]};
            timeoutBits = `UEB_TO_CHARS * perChar + `UEB_TO_BITS;
        end
    endfunction

    reg rstMeta_reg; // First reset stage, read only by the second.
    reg rstN; // Released reset used by the whole bank.
    reg [7:0] intEnable_reg; // Interrupt enables, read back as written except shaded bits 7:4.
    reg fifoEnable_reg; // FIFO mode.
    reg [1:0] rxTrigSel_reg; // Receive trigger selection.
    reg [5:4] txTrigSel_reg; // Transmit trigger bits, enhanced only.
    reg [7:0] gpioMask_reg; // GPIO interrupt mask.
    reg dataReady_reg; // Receive data ready status.
    reg txIntFlag_reg; // Transmit ready event held until serviced.
    reg timeoutFlag_reg; // Receive time-out event.
    reg [6:0] toCount_reg; // Bit times since the last receive activity.
    reg gpioFlag_reg; // GPIO toggle event.
    reg [7:0] gpioPrev_reg; // Input levels one cycle ago.
    reg [7:0] gpioHold_reg; // Input levels as shown to the host.
    reg txEmptyPrev_reg; // For the rising edge of transmit empty.
    reg [7:0] rdLocal_reg; // Read data gathered at the take edge.
    reg rdFromMem_reg; // The read targets the character store.
    reg rdStage_reg; // A read is in its first cycle.
    wire [7:0] memData; // Registered output of the character store.

    wire keyMode = (lineCtrl == `UEB_KEY);
    wire divMode = lineCtrl[`UEB_LCR_DIV] & ~keyMode;
    wire enh = enhancedCtrl[`UEB_EFR_ENH];
    wire memHit = keyMode & (regAddr[3:2] == `UEB_A_CHARS);
    wire [6:0] trig = trigLevel(rxTrigSel_reg);

    // Decoded accesses with side effects.
    wire normMap = ~keyMode & ~divMode;
    wire holdRd = regRd & normMap & (regAddr == `UEB_A_HOLD);
    wire holdWr = regWr & normMap & (regAddr == `UEB_A_HOLD);
    wire isrRd = regRd & normMap & (regAddr == `UEB_A_ISR);
    wire gpioRd = regRd & ~memHit & (regAddr == `UEB_A_GPST);
    wire ierWr = regWr & normMap & (regAddr == `UEB_A_IER);

    // Interrupt sources, each gated by its enable.
    wire rxFifoMode = fifoEnable_reg & intEnable_reg[`UEB_IER_RX];
    wire rxLevel = fifoEnable_reg ? (rxFifoCount >= trig) : dataReady_reg;
    wire lsInt = intEnable_reg[`UEB_IER_LS] & (|(lineStatusIn & `UEB_M_LSERR));
    wire toInt = rxFifoMode & timeoutFlag_reg;
    wire rxInt = intEnable_reg[`UEB_IER_RX] & rxLevel;
    wire txInt = intEnable_reg[`UEB_IER_TX] & txIntFlag_reg;
    wire msInt = intEnable_reg[`UEB_IER_MS] & modemInt;
    wire gpInt = enh & gpioFlag_reg;
    reg [5:0] isrCode;

    // Highest pending source wins; nothing pending reads as the none code.
    always @* begin
        if (lsInt) begin
            isrCode = `UEB_ISR_LS;
        end else if (toInt) begin
            isrCode = `UEB_ISR_TO;
        end else if (rxInt) begin
            isrCode = `UEB_ISR_RX;
        end else if (txInt) begin
            isrCode = `UEB_ISR_TX;
        end else if (msInt) begin
            isrCode = `UEB_ISR_MS;
        end else if (gpInt) begin
            isrCode = `UEB_ISR_GPIO;
        end else begin
            isrCode = `UEB_ISR_NONE;
        end
    end

    reg [7:0] rdMux;

    // Read mux; the map depends on line_ctrl. Unmapped offsets read zero.
    always @* begin
        rdMux = 8'h00;
        if (keyMode) begin
            case (regAddr)
                `UEB_A_DLL: rdMux = divisorLow;
                `UEB_A_DLM: rdMux = divisorHigh;
                `UEB_A_EFR: rdMux = enhancedCtrl;
                `UEB_A_LCR: rdMux = lineCtrl;
                default: rdMux = 8'h00;
            endcase
        end else if (divMode && regAddr < `UEB_A_LCR) begin
            case (regAddr)
                `UEB_A_DLL: rdMux = divisorLow;
                `UEB_A_DLM: rdMux = divisorHigh;
                default: rdMux = divisorFraction;
            endcase
        end else begin
            case (regAddr)
                `UEB_A_HOLD: rdMux = rxFifoHead;
                `UEB_A_IER: rdMux = intEnable_reg;
                `UEB_A_ISR: rdMux = {fifoEnable_reg, fifoEnable_reg, isrCode};
                `UEB_A_LCR: rdMux = lineCtrl;
                `UEB_A_LSR: rdMux = {lineStatusIn, dataReady_reg};
                default: rdMux = 8'h00;
            endcase
        end
        // The GPIO and control block sits at the same offsets in every map.
        case (regAddr)
            `UEB_A_GPST: rdMux = gpioHold_reg;
            `UEB_A_GPMSK: rdMux = gpioMask_reg;
            `UEB_A_RSVD: rdMux = 8'h00;
            `UEB_A_IOCTL: rdMux = ioPinCtrl;
            `UEB_A_EXTRA_FEATURE_CONTROL: rdMux = extraCtrl;
            default: rdMux = rdMux;
        endcase
    end

    // Reset is asserted at once and released through two flip-flops.
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rstMeta_reg <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstN <= rstMeta_reg;
        end
    end

    // Host writes. Pulse outputs last one cycle after the write edge.
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            intEnable_reg <= `UEB_RST_BYTE;
            fifoEnable_reg <= 1'b0;
            rxTrigSel_reg <= 2'h0;
            txTrigSel_reg <= 2'h0;
            lineCtrl <= `UEB_RST_LCR;
            divisorLow <= `UEB_RST_BYTE;
            divisorHigh <= `UEB_RST_BYTE;
            divisorFraction <= `UEB_RST_BYTE;
            enhancedCtrl <= `UEB_RST_BYTE;
            extraCtrl <= `UEB_RST_BYTE;
            gpioOut <= `UEB_RST_BYTE;
            gpioMask_reg <= `UEB_RST_BYTE;
            ioPinCtrl <= `UEB_RST_BYTE;
            txData <= `UEB_RST_BYTE;
            txPush <= 1'b0;
            rxFifoClear <= 1'b0;
            txFifoClear <= 1'b0;
        end else begin
            txPush <= holdWr;
            rxFifoClear <= 1'b0;
            txFifoClear <= 1'b0;
            if (holdWr) begin
                txData <= regWrData;
            end
            if (regWr && keyMode) begin
                // Key map: divisor pair and enhanced control.
                case (regAddr)
                    `UEB_A_DLL: divisorLow <= regWrData;
                    `UEB_A_DLM: divisorHigh <= regWrData;
                    `UEB_A_EFR: enhancedCtrl <= regWrData;
                    default: ;
                endcase
            end else if (regWr && divMode && regAddr < `UEB_A_LCR) begin
                case (regAddr)
                    `UEB_A_DLL: divisorLow <= regWrData;
                    `UEB_A_DLM: divisorHigh <= regWrData;
                    default: divisorFraction <= enh ? regWrData
                        : (regWrData & `UEB_M_DLD_STD) | (divisorFraction & ~`UEB_M_DLD_STD);
                endcase
            end else if (regWr && normMap) begin
                case (regAddr)
                    `UEB_A_IER: intEnable_reg <= enh ? regWrData
                        : (regWrData & `UEB_M_IER_STD) | (intEnable_reg & ~`UEB_M_IER_STD);
                    `UEB_A_ISR: begin
                        fifoEnable_reg <= regWrData[`UEB_FCR_EN];
                        rxTrigSel_reg <= regWrData[7:6];
                        rxFifoClear <= regWrData[`UEB_FCR_RXCLR];
                        txFifoClear <= regWrData[`UEB_FCR_TXCLR];
                        if (enh) begin
                            txTrigSel_reg <= regWrData[5:4];
                        end
                    end
                    default: ;
                endcase
            end
            // Line control and the GPIO block are writable in every map.
            if (regWr && !memHit) begin
                case (regAddr)
                    `UEB_A_LCR: lineCtrl <= regWrData;
                    `UEB_A_GPST: gpioOut <= regWrData;
                    `UEB_A_GPMSK: gpioMask_reg <= regWrData;
                    `UEB_A_IOCTL: ioPinCtrl <= regWrData & `UEB_M_IOCTL;
                    `UEB_A_EXTRA_FEATURE_CONTROL: extraCtrl <= regWrData & `UEB_M_EXTRA_FEATURE_CONTROL;
                    default: ;
                endcase
            end
        end
    end

    // Receive and transmit status and events. Wherever a set meets a clear, the set wins.
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            dataReady_reg <= 1'b0;
            txIntFlag_reg <= 1'b0;
            txEmptyPrev_reg <= 1'b0;
            timeoutFlag_reg <= 1'b0;
            toCount_reg <= 7'h00;
            rxPop <= 1'b0;
        end else begin
            rxPop <= holdRd;
            // Data ready sets on each push and drops only once the FIFO is empty.
            if (rxPush) begin
                dataReady_reg <= 1'b1;
            end else if (rxFifoCount == 7'h00) begin
                dataReady_reg <= 1'b0;
            end
            // Transmit ready: edge of empty, or enabled while already empty.
            txEmptyPrev_reg <= txEmpty;
            if ((txEmpty && !txEmptyPrev_reg)
                || (ierWr && regWrData[`UEB_IER_TX] && txEmpty)) begin
                txIntFlag_reg <= 1'b1;
            end else if (isrRd || holdWr) begin
                txIntFlag_reg <= 1'b0;
            end
            // Time-out counter restarts on any receive activity and only
            // runs while data waits; a read of the holding location clears it.
            if (rxPush || holdRd || rxFifoCount == 7'h00) begin
                toCount_reg <= 7'h00;
            end else if (bitTick && toCount_reg != timeoutBits(lineCtrl)) begin
                toCount_reg <= toCount_reg + 7'h01;
            end
            // Set on the tick that ends the count, so a holding read is not undone after it.
            if (bitTick && !rxPush && rxFifoCount != 7'h00
                && toCount_reg + 7'h01 == timeoutBits(lineCtrl)) begin
                timeoutFlag_reg <= 1'b1;
            end else if (holdRd) begin
                timeoutFlag_reg <= 1'b0;
            end
        end
    end

    // GPIO inputs: toggles raise an event cleared by reading the state register.
    // With the hold bit set the shown value freezes until that read.
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            gpioPrev_reg <= 8'h00;
            gpioHold_reg <= 8'h00;
            gpioFlag_reg <= 1'b0;
        end else begin
            gpioPrev_reg <= gpioIn;
            if (!ioPinCtrl[`UEB_IOC_HOLD] || gpioRd) begin
                gpioHold_reg <= gpioIn;
            end
            if (|((gpioIn ^ gpioPrev_reg) & gpioMask_reg)) begin
                gpioFlag_reg <= 1'b1;
            end else if (gpioRd) begin
                gpioFlag_reg <= 1'b0;
            end
        end
    end

    // Read pipeline: capture at the take edge, present one edge later.
    // The extra stage keeps every output on a flip-flop, at one cycle of latency.
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            rdLocal_reg <= 8'h00;
            rdFromMem_reg <= 1'b0;
            rdStage_reg <= 1'b0;
            regRdData <= 8'h00;
            regRdValid <= 1'b0;
            irq <= 1'b0;
        end else begin
            rdStage_reg <= regRd;
            if (regRd) begin
                rdLocal_reg <= rdMux;
                rdFromMem_reg <= memHit;
            end
            regRdValid <= rdStage_reg;
            if (rdStage_reg) begin
                regRdData <= rdFromMem_reg ? memData : rdLocal_reg;
            end
            irq <= (isrCode != `UEB_ISR_NONE);
        end
    end

    // Flow-control characters, reachable only through the key map.
    ueb_char_mem charMem (
        .mclk(mclk),
        .rstN(rstN),
        .wrEn(regWr & memHit),
        .wrAddr(regAddr[1:0]),
        .wrData(regWrData),
        .rdAddr(regAddr[1:0]),
        .rdData(memData)
    );
endmodule

// *** ueb_defs.vh ***
// Constants for the UART enhanced register bank: offsets, bit positions, codes, timing.
`ifndef UEB_DEFS_VH
`define UEB_DEFS_VH

// Register offsets in the normal map.
`define UEB_A_HOLD 4'h0
`define UEB_A_IER 4'h1
`define UEB_A_ISR 4'h2
`define UEB_A_LCR 4'h3
`define UEB_A_LSR 4'h5
`define UEB_A_GPST 4'hB
`define UEB_A_GPMSK 4'hC
`define UEB_A_RSVD 4'hD
`define UEB_A_IOCTL 4'hE
`define UEB_A_EXTRA_FEATURE_CONTROL 4'hF
// Offsets in the divisor and key maps.
`define UEB_A_DLL 4'h0
`define UEB_A_DLM 4'h1
`define UEB_A_DLD 4'h2
`define UEB_A_EFR 4'h2
// Upper two address bits that select the flow-control characters.
`define UEB_A_CHARS 2'h1

// Key value of line_ctrl that opens the enhanced map.
`define UEB_KEY 8'hBF
// Bit positions.
`define UEB_LCR_DIV 7
`define UEB_EFR_ENH 4
`define UEB_FCR_EN 0
`define UEB_FCR_RXCLR 1
`define UEB_FCR_TXCLR 2
`define UEB_IER_RX 0
`define UEB_IER_TX 1
`define UEB_IER_LS 2
`define UEB_IER_MS 3
`define UEB_IOC_HOLD 0

// Masks: shaded and fixed-zero write bits, and the line status error bits.
`define UEB_M_IER_STD 8'h0F
`define UEB_M_DLD_STD 8'hCF
`define UEB_M_IOCTL 8'h0B
`define UEB_M_EXTRA_FEATURE_CONTROL 8'hB7
`define UEB_M_LSERR 7'h4F

// Interrupt source codes, bits 5..0 of int_status_reg.
`define UEB_ISR_NONE 6'h01
`define UEB_ISR_LS 6'h06
`define UEB_ISR_TO 6'h0C
`define UEB_ISR_RX 6'h04
`define UEB_ISR_TX 6'h02
`define UEB_ISR_MS 6'h00
`define UEB_ISR_GPIO 6'h30

// Receive trigger levels for fifo_ctrl bits 7:6, in characters.
`define UEB_TRIG0 7'h01
`define UEB_TRIG1 7'h04
`define UEB_TRIG2 7'h08
`define UEB_TRIG3 7'h0E

// Receive time-out: whole characters plus extra bit times.
`define UEB_TO_CHARS 7'h04
`define UEB_TO_BITS 7'h0C
// Bits of a character at five data bits: five data, one start and one stop bit.
`define UEB_FRAME_BASE 7'h07

// Reset values.
`define UEB_RST_BYTE 8'h00
`define UEB_RST_LCR 8'h00
`endif

// *** ueb_char_mem.v ***
// Four-word store for the flow-control characters, with a registered read port.
`timescale 1ns/1ps
module ueb_char_mem (
    input wire mclk,
    input wire rstN,
    input wire wrEn,
    input wire [1:0] wrAddr,
    input wire [7:0] wrData,
    input wire [1:0] rdAddr,
    output reg [7:0] rdData
);
    // Words: resume one, resume two, pause one, pause two.
    reg [7:0] word_reg [0:3];
    integer i;

    // Writes land at once; read data is sampled one edge after the address.
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            for (i = 0; i < 4; i = i + 1) begin
                word_reg[i] <= 8'h00;
            end
            rdData <= 8'h00;
        end else begin
            if (wrEn) begin
                word_reg[wrAddr] <= wrData;
            end
            rdData <= word_reg[rdAddr];
        end
    end
endmodule

// *** ueb_rx_line_model.sv ***
// Behavioural model of the receive line engine and its FIFO facing the bank.
`timescale 1ns/1ps
module ueb_rx_line_model (
    input wire mclk,
    input wire nrst,
    input wire pushReq,
    input wire [7:0] pushData,
    input wire rxPop,
    input wire rxFifoClear,
    output logic [6:0] rxFifoCount,
    output logic [7:0] rxFifoHead,
    output logic rxPush
);
    logic [7:0] fifoQ[$]; // Characters waiting, oldest first.
    logic [7:0] lastHead; // Last head shown, so an empty FIFO shows its inverse.
    // Pops, clears and pushes land on the clock edge, as the real engine would.
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fifoQ.delete();
            rxFifoCount <= 7'h00;
            rxFifoHead <= 8'h00;
            lastHead = 8'h00;
            rxPush <= 1'b0;
        end else begin
            rxPush <= pushReq;
            if (rxFifoClear) begin
                fifoQ.delete();
            end else begin
                // A pop on an empty FIFO is ignored.
                if (rxPop && fifoQ.size() > 0) begin
                    void'(fifoQ.pop_front());
                end
                if (pushReq) begin
                    fifoQ.push_back(pushData);
                end
            end
            rxFifoCount <= 7'(fifoQ.size());
            // An empty FIFO must not keep showing a stale character.
            if (fifoQ.size() > 0) begin
                lastHead = fifoQ[0];
                rxFifoHead <= fifoQ[0];
            end else begin
                rxFifoHead <= ~lastHead;
            end
        end
    end
endmodule

// *** ueb_bank_asserts.sv ***
// Concurrent checks on the register bank's ports.
`timescale 1ns/1ps
module ueb_bank_asserts (
    input wire mclk,
    input wire nrst,
    input wire [3:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWr,
    input wire regRd,
    input wire regRdValid,
    input wire rxPop,
    input wire txPush,
    input wire [7:0] txData,
    input wire [7:0] divisorLow,
    input wire [7:0] divisorFraction,
    input wire [7:0] lineCtrl,
    input wire [7:0] enhancedCtrl
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Every read is answered exactly two cycles after it is taken.
    chk_read_answer: assert property (regRd |-> ##2 regRdValid)
        else $error("read answer missing");
    chk_hold_pop: assert property (regRd && regAddr == 4'h0 && !lineCtrl[7] |=> rxPop)
        else $error("holding read did not pop");
    chk_hold_push: assert property (regWr && regAddr == 4'h0 && !lineCtrl[7]
        |=> txPush && txData == $past(regWrData)) else $error("holding write lost");
    chk_read_nopush: assert property (regRd |=> !txPush)
        else $error("read queued a character");
    chk_div_write: assert property (regWr && regAddr == 4'h0 && lineCtrl[7]
        |=> divisorLow == $past(regWrData)) else $error("divisor write lost");
    chk_div_hidden: assert property (regWr && !lineCtrl[7] |=> $stable(divisorLow))
        else $error("divisor changed while hidden");
    chk_key_write: assert property (regWr && regAddr == 4'h2 && lineCtrl == 8'hBF
        |=> enhancedCtrl == $past(regWrData)) else $error("enhanced write lost");
    chk_key_locked: assert property (regWr && lineCtrl != 8'hBF |=> $stable(enhancedCtrl))
        else $error("enhanced changed without key");
    chk_shaded_frac: assert property (regWr && regAddr == 4'h2 && lineCtrl[7]
        && lineCtrl != 8'hBF && !enhancedCtrl[4] |=> $stable(divisorFraction[5:4]))
        else $error("shaded divisor bits written");
endmodule

// *** tb_top.sv ***
// Self-checking testbench of the register bank with a receive FIFO model.
`timescale 1ns/1ps
module tb_top;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic bitTick = 1'b0;
    logic [7:1] lineStatusIn = 7'h00;
    logic modemInt = 1'b0;
    logic txEmpty = 1'b0;
    logic pushReq = 1'b0;
    logic [7:0] pushData = 8'h00;
    wire [7:0] regRdData;
    wire regRdValid, rxPop, txPush, rxFifoClear, irq, rxPush;
    wire [7:0] txData, divisorLow, divisorFraction, lineCtrl, enhancedCtrl;
    wire [6:0] rxFifoCount;
    wire [7:0] rxFifoHead;
    int bad_count = 0; // Mismatches seen.
    int checks = 0; // Comparisons made.
    int cycles = 0; // Cycle counter for the hang guard.
    always #4 mclk = ~mclk; // 125 MHz.
    ueb_register_bank u_dut (.mclk(mclk), .nrst(nrst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .regRdValid(regRdValid), .rxFifoCount(rxFifoCount), .rxFifoHead(rxFifoHead),
        .rxPush(rxPush), .bitTick(bitTick), .txEmpty(txEmpty), .lineStatusIn(lineStatusIn),
        .modemInt(modemInt), .gpioIn(8'h00), .rxPop(rxPop), .txPush(txPush),
        .txData(txData), .rxFifoClear(rxFifoClear), .txFifoClear(), .irq(irq),
        .divisorLow(divisorLow), .divisorHigh(), .divisorFraction(divisorFraction),
        .lineCtrl(lineCtrl), .enhancedCtrl(enhancedCtrl), .extraCtrl(), .gpioOut(),
        .ioPinCtrl());
    ueb_rx_line_model u_line (.mclk(mclk), .nrst(nrst), .pushReq(pushReq),
        .pushData(pushData), .rxPop(rxPop), .rxFifoClear(rxFifoClear),
        .rxFifoCount(rxFifoCount), .rxFifoHead(rxFifoHead), .rxPush(rxPush));
    // Prints the counts and the verdict, then stops the run.
    task automatic results();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Compares one byte and reports a difference at once.
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // One write strobe, driven at the falling edge and taken at the next rise.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge mclk);
        regAddr = a;
        regWrData = d;
        regWr = 1'b1;
        @(negedge mclk);
        regWr = 1'b0;
    endtask
    // One read; the answer is due one cycle after the take edge.
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
        @(negedge mclk);
        regAddr = a;
        regRd = 1'b1;
        @(negedge mclk);
        regRd = 1'b0;
        @(posedge mclk);
        #1;
        chk8({n, " valid"}, 8'h01, {7'h00, regRdValid});
        chk8(n, e, regRdData);
    endtask
    // Hands one character to the line model and lets the status settle.
    task automatic push(input logic [7:0] d);
        @(negedge mclk);
        pushReq = 1'b1;
        pushData = d;
        @(negedge mclk);
        pushReq = 1'b0;
        repeat (3) @(negedge mclk);
    endtask
    // Single-cycle bit-time pulses.
    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge mclk);
            bitTick = 1'b1;
            @(negedge mclk);
            bitTick = 1'b0;
        end
    endtask
    always @(posedge mclk) begin
        cycles++;
        // Far above the few hundred cycles the tests need.
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        repeat (20) @(negedge mclk);
        nrst = 1'b1;
        repeat (3) @(negedge mclk);
        rd(4'h2, 8'h01, "status at reset");
        rd(4'h1, 8'h00, "enable at reset");
        rd(4'hD, 8'h00, "reserved slot");
        wr(4'h1, 8'hFF);
        rd(4'h1, 8'h0F, "enable shaded");
        wr(4'h1, 8'h05);
        rd(4'h1, 8'h05, "enable readback");
        $display("test registers done");
        wr(4'h3, 8'h80);
        wr(4'h0, 8'h5A);
        wr(4'h2, 8'hFF);
        rd(4'h0, 8'h5A, "divisor low");
        rd(4'h2, 8'hCF, "fraction shaded");
        wr(4'h3, 8'hBF);
        wr(4'h2, 8'h10);
        for (int i = 4; i < 8; i++) wr(4'(i), 8'(i * 17));
        for (int i = 4; i < 8; i++) rd(4'(i), 8'(i * 17), "flow char");
        rd(4'h2, 8'h10, "enhanced ctrl");
        wr(4'h3, 8'h80);
        wr(4'h2, 8'hFF);
        rd(4'h2, 8'hFF, "fraction full");
        wr(4'h3, 8'h03);
        wr(4'h0, 8'h77);
        chk8("divisor kept", 8'h5A, divisorLow);
        $display("test maps done");
        wr(4'h2, 8'h41);
        wr(4'h1, 8'h01);
        for (int i = 1; i < 4; i++) push(8'(8'hA0 + i));
        rd(4'h5, 8'h01, "data ready");
        rd(4'h2, 8'hC1, "below trigger");
        push(8'hA4);
        rd(4'h2, 8'hC4, "at trigger");
        chk8("irq raised", 8'h01, {7'h00, irq});
        rd(4'h0, 8'hA1, "holding first");
        rd(4'h2, 8'hC1, "fell below");
        chk8("irq withdrawn", 8'h00, {7'h00, irq});
        wr(4'h0, 8'h66);
        rd(4'h0, 8'hA2, "holding second");
        ticks(51);
        rd(4'h2, 8'hC1, "timeout early");
        ticks(1);
        rd(4'h2, 8'hCC, "timeout");
        rd(4'h0, 8'hA3, "holding third");
        rd(4'h2, 8'hC1, "timeout cleared");
        rd(4'h5, 8'h01, "ready kept");
        rd(4'h0, 8'hA4, "holding last");
        // Data ready drops one edge after the pop empties the FIFO.
        @(negedge mclk);
        rd(4'h5, 8'h00, "ready cleared");
        $display("test receive done");
        wr(4'h1, 8'h00);
        for (int i = 0; i < 4; i++) push(8'(i));
        rd(4'h2, 8'hC1, "rx masked");
        wr(4'h1, 8'h08);
        modemInt = 1'b1;
        rd(4'h2, 8'hC0, "modem source");
        @(negedge mclk);
        modemInt = 1'b0;
        txEmpty = 1'b1;
        wr(4'h1, 8'h02);
        rd(4'h2, 8'hC2, "transmit source");
        rd(4'h2, 8'hC1, "transmit serviced");
        @(negedge mclk);
        lineStatusIn = 7'h01;
        wr(4'h1, 8'h04);
        rd(4'h2, 8'hC6, "line source");
        chk8("irq line", 8'h01, {7'h00, irq});
        @(negedge mclk);
        lineStatusIn = 7'h00;
        wr(4'h2, 8'h43);
        repeat (3) @(negedge mclk);
        rd(4'h5, 8'h00, "fifo cleared");
        $display("test sources done");
        results();
    end
endmodule
bind ueb_register_bank ueb_bank_asserts u_chk (.mclk(mclk), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdValid(regRdValid),
    .rxPop(rxPop), .txPush(txPush), .txData(txData), .divisorLow(divisorLow),
    .divisorFraction(divisorFraction), .lineCtrl(lineCtrl), .enhancedCtrl(enhancedCtrl));
